/* File: rtl/fsp_flash_security.sv */
// fsp_flash_security.sv: flash security, backdoor key, block protection and command flags
// assumes: nonvolatile bytes are stable from reset, cpu and debug register ports are on core_clk
//
// Functional notes
// - debug module enable refused while secure
// - secure: background entry only via pin
// - key disabled leaves only full erase
// - key mode turns key writes into compares
// - no key writes on adjacent cycles
// - key match on exit sets unsecured
// - key accepted only from ram code
// - key lives in protected vector block
// - protect register writable only by debug
// - blank check pass unsecures until reset
// - reset loads protect register from nvm
// - select field gives unprotected end address
// - disable bit one protects no block
// - status bits 3,1,0 read zero
// - buffer empty flag launches, clears, buffers
// - complete flag sets when idle, ignores writes
`include "fsp_regs.svh"
module fsp_flash_security
  import fsp_pkg::*;
#(
  parameter int         ADDR_W = 16,
  parameter int         CMD_CYC = `FSP_CMD_CYC,
  parameter logic [15:0] FLASH_TOP = 16'hffff
)(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        nv_options_byte,
  input  wire logic [7:0]        nv_protect_byte,
  input  wire logic [63:0]       nv_backdoor_key,
  input  wire logic              background_mode_select_pin,
  input  wire logic              dbg_enable_req,
  input  wire logic              bgnd_entry_req,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [2:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_from_debug,
  input  wire logic              reg_from_ram,
  output logic      [7:0]        reg_rdata,
  input  wire logic              flash_wr,
  input  wire logic [ADDR_W-1:0] flash_addr,
  input  wire logic [7:0]        flash_wdata,
  input  wire logic [ADDR_W-1:0] key_base_addr,
  input  wire logic              blank_check_done,
  input  wire logic              blank_check_pass,
  input  wire logic              cmd_burst,
  output logic                   flash_latch_wr,
  output logic                   cmd_start,
  output logic                   cmd_reject,
  output logic                   secure,
  output logic                   debug_enable,
  output logic                   bgnd_entry
);

  // ****************************************
  // pin synchroniser and reset capture
  // ****************************************
  logic       ms_meta_reg;
  logic       ms_sync_reg;
  logic       rst_seen_reg;
  logic       ms_low_at_reset_reg;
  always_ff @(posedge core_clk)
  begin
    ms_meta_reg <= background_mode_select_pin;
    ms_sync_reg <= ms_meta_reg;
  end

  // the pin is caught on the first clocked edge after release, never under reset itself
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rst_seen_reg <= 1'b0;
    else
      rst_seen_reg <= 1'b1;
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ms_low_at_reset_reg <= 1'b0;
    else if (!rst_seen_reg)
      ms_low_at_reset_reg <= ~ms_sync_reg;
  end

  // ****************************************
  // security state
  // ****************************************
  logic [1:0] sec_bits_reg;
  logic [1:0] sec_bits_next;
  logic       loaded_reg;
  logic       key_match;
  logic       key_unlock;
  logic       blank_unlock;
  logic       key_enable;
  logic [7:0] opt_shadow_reg;
  assign key_enable = opt_shadow_reg[`FSP_OPT_KEY_EN];
  assign blank_unlock = blank_check_done & blank_check_pass & reg_from_debug;
  assign sec_bits_next = (key_unlock | blank_unlock) ? `FSP_SEC_OPEN : sec_bits_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      loaded_reg     <= 1'b0;
      sec_bits_reg   <= 2'h0;
      opt_shadow_reg <= 8'h00;
    end
    else if (!loaded_reg)
    begin
      loaded_reg     <= 1'b1;
      sec_bits_reg   <= nv_options_byte[1:0];
      opt_shadow_reg <= nv_options_byte;
    end
    else
      sec_bits_reg <= sec_bits_next;
  end
  assign secure = ~loaded_reg | (sec_bits_reg != `FSP_SEC_OPEN);
  assign debug_enable = dbg_enable_req & ~secure;
  assign bgnd_entry = secure ? ms_low_at_reset_reg : bgnd_entry_req;

  // ****************************************
  // backdoor key capture
  // ****************************************
  logic       key_mode_reg;
  logic [7:0] key_ok_reg;
  logic       key_wr_hit;
  logic       key_wr_prev_reg;
  logic [2:0] key_idx;
  logic       cfg_wr;
  logic       key_mode_fall;
  logic [ADDR_W-1:0] key_off;
  assign key_off = flash_addr - key_base_addr;
  assign key_idx = key_off[2:0];
  // key mode writes to the key bytes never reach the array; ram-only and not back to back
  assign key_wr_hit = flash_wr & key_mode_reg & (key_off < ADDR_W'(`FSP_KEY_BYTES));
  assign cfg_wr = reg_wr & (reg_addr == `FSP_OFF_CFG) & reg_from_ram & ~reg_from_debug;
  assign key_mode_fall = cfg_wr & key_mode_reg & ~reg_wdata[`FSP_CFG_KEY_MODE];
  assign key_match = (key_ok_reg == 8'hff);
  assign key_unlock = key_mode_fall & key_enable & key_match;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      key_mode_reg    <= 1'b0;
      key_ok_reg      <= 8'h00;
      key_wr_prev_reg <= 1'b0;
    end
    else
    begin
      key_wr_prev_reg <= key_wr_hit;
      if (cfg_wr)
        key_mode_reg <= reg_wdata[`FSP_CFG_KEY_MODE] & key_enable;
      if (cfg_wr & reg_wdata[`FSP_CFG_KEY_MODE] & ~key_mode_reg)
        key_ok_reg <= 8'h00;
      else if (key_wr_hit & ~key_wr_prev_reg & reg_from_ram)
        key_ok_reg[key_idx] <= (flash_wdata == nv_backdoor_key[key_idx*8 +: 8]);
    end
  end

  // ****************************************
  // block protection
  // ****************************************
  logic [7:0] prot_reg;
  logic       prot_wr;
  logic       in_protected;
  logic [ADDR_W-1:0] prot_limit;
  assign prot_wr = reg_wr & (reg_addr == `FSP_OFF_PROT) & reg_from_debug;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      prot_reg <= 8'hff;
    else if (!loaded_reg)
      prot_reg <= nv_protect_byte;
    else if (prot_wr)
      prot_reg <= reg_wdata;
  end
  // select field gives the upper bits of the last unprotected address, 512-byte granules
  assign prot_limit = ADDR_W'({prot_reg[7:1], 9'h1ff});
  assign in_protected = ~prot_reg[`FSP_PROT_DIS] & (flash_addr > prot_limit);

  // ****************************************
  // command buffer and status flags
  // ****************************************
  fsp_cmd_t   cmd_state_reg;
  logic [15:0] busy_cnt_reg;
  logic       cbef_reg;
  logic       buffered_reg;
  logic       launch;
  logic       stat_wr;
  logic       ccf;
  assign flash_latch_wr = flash_wr & ~key_wr_hit & ~in_protected;
  assign cmd_reject = flash_wr & ~key_wr_hit & in_protected;
  assign stat_wr = reg_wr & (reg_addr == `FSP_OFF_STAT);
  assign launch = stat_wr & reg_wdata[`FSP_STAT_CBEF] & cbef_reg;
  assign cmd_start = launch;
  assign ccf = cbef_reg & (cmd_state_reg == FSP_IDLE);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cmd_state_reg <= FSP_IDLE;
      busy_cnt_reg  <= 16'h0000;
      cbef_reg      <= 1'b1;
      buffered_reg  <= 1'b0;
    end
    else
    begin
      case (cmd_state_reg)
        FSP_IDLE:
          if (launch)
          begin
            cmd_state_reg <= FSP_BUSY;
            busy_cnt_reg  <= 16'(CMD_CYC);
            // a burst moves straight to the array, so the buffer is free for the next one
            cbef_reg      <= cmd_burst;
          end
        FSP_BUSY:
          if (launch & cmd_burst)
          begin
            buffered_reg <= 1'b1;
            cbef_reg     <= 1'b0;
          end
          else if (busy_cnt_reg <= 16'h0001)
            cmd_state_reg <= FSP_NEXT;
          else
            busy_cnt_reg <= busy_cnt_reg - 16'h0001;
        FSP_NEXT:
          if (buffered_reg)
          begin
            buffered_reg  <= 1'b0;
            cbef_reg      <= 1'b1;
            busy_cnt_reg  <= 16'(CMD_CYC);
            cmd_state_reg <= FSP_BUSY;
          end
          else
          begin
            cbef_reg      <= 1'b1;
            cmd_state_reg <= FSP_IDLE;
          end
        default:
          cmd_state_reg <= FSP_IDLE;
      endcase
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  logic [7:0] stat_val;
  assign stat_val = {cbef_reg, ccf, 6'h00} & `FSP_STAT_MASK;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      case (reg_addr)
        `FSP_OFF_PROT: reg_rdata <= prot_reg;
        `FSP_OFF_STAT: reg_rdata <= stat_val;
        `FSP_OFF_CFG:  reg_rdata <= {2'h0, key_mode_reg, 5'h00};
        `FSP_OFF_OPT:  reg_rdata <= {opt_shadow_reg[7:2], sec_bits_reg};
        default:       reg_rdata <= 8'h00;
      endcase
  end

  // ****************************************
  // checks
  // ****************************************
  chk_debug_secure: assert property (@(posedge core_clk) disable iff (!rst_n)
    secure |-> !debug_enable) else $error("debug enabled while secure");
  chk_key_no_prog: assert property (@(posedge core_clk) disable iff (!rst_n)
    key_wr_hit |-> !flash_latch_wr) else $error("key write reached array");
  chk_key_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
    (loaded_reg && !key_enable && !blank_unlock && secure) |=> secure) else $error("unlock without key enable");
  chk_prot_app: assert property (@(posedge core_clk) disable iff (!rst_n)
    (loaded_reg && reg_wr && !reg_from_debug) |=> $stable(prot_reg)) else $error("app changed protection");
  chk_key_unlock: assert property (@(posedge core_clk) disable iff (!rst_n)
    (loaded_reg && key_unlock) |=> !secure) else $error("key match did not unsecure");
  chk_blank_unlock: assert property (@(posedge core_clk) disable iff (!rst_n)
    (loaded_reg && blank_unlock) |=> !secure) else $error("blank check did not unsecure");
  chk_prot_region: assert property (@(posedge core_clk) disable iff (!rst_n)
    (flash_wr && prot_reg[0]) |-> !cmd_reject) else $error("rejected with protection off");
  chk_stat_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `FSP_OFF_STAT) |=> (reg_rdata[3] == 1'b0) && (reg_rdata[1:0] == 2'h0))
    else $error("reserved status bit set");
  chk_ccf_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    launch |=> !ccf) else $error("complete flag not cleared");
  chk_cbef_launch: assert property (@(posedge core_clk) disable iff (!rst_n)
    (launch && cmd_burst && cmd_state_reg == FSP_BUSY) |=> !cbef_reg) else $error("buffer flag kept");
  chk_key_adjacent: assert property (@(posedge core_clk) disable iff (!rst_n)
    (key_wr_hit && key_wr_prev_reg && !cfg_wr) |=> $stable(key_ok_reg)) else $error("adjacent key write counted");
  cov_key_unlock:   cover property (@(posedge core_clk) disable iff (!rst_n) key_unlock);
  cov_blank_unlock: cover property (@(posedge core_clk) disable iff (!rst_n) blank_unlock);
  cov_burst:        cover property (@(posedge core_clk) disable iff (!rst_n) buffered_reg ##1 !buffered_reg);
  cov_reject:       cover property (@(posedge core_clk) disable iff (!rst_n) cmd_reject);
  cov_plain_cmd:    cover property (@(posedge core_clk) disable iff (!rst_n) launch && !cmd_burst);
endmodule

/* File: rtl/fsp_pkg.sv */
// fsp_pkg.sv: types of the flash security block
// assumes: the register header, which it includes but does not use
`include "fsp_regs.svh"
package fsp_pkg;
  typedef enum logic [1:0] {
    FSP_IDLE = 2'b00,
    FSP_BUSY = 2'b01,
    FSP_NEXT = 2'b11
  } fsp_cmd_t;
endpackage

/* File: rtl/fsp_regs.svh */
// fsp_regs.svh: register offsets, field positions and reset values of the flash security block
// assumes: included by the package and the design file; definitions only
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH
// byte offsets on the local register port, chosen locally
`define FSP_OFF_PROT      3'h0
`define FSP_OFF_STAT      3'h1
`define FSP_OFF_CFG       3'h2
`define FSP_OFF_OPT       3'h3
// field positions
`define FSP_STAT_CBEF     7
`define FSP_STAT_CCF      6
`define FSP_STAT_MASK     8'hf4
`define FSP_CFG_KEY_MODE  5
`define FSP_OPT_KEY_EN    7
`define FSP_PROT_DIS      0
// security encoding meaning unsecured
`define FSP_SEC_OPEN      2'h2
`define FSP_KEY_BYTES     8
`define FSP_VEC_BLOCK     16'h0200
// reset values
`define FSP_STAT_RST      8'hc0
`define FSP_CFG_RST       8'h00
// busy time of one array command, in ns, and its cycles at 250 MHz
`define FSP_CMD_NS        40
`define FSP_CLK_MHZ       250
`define FSP_CMD_CYC       ((`FSP_CMD_NS * `FSP_CLK_MHZ + 999) / 1000)
`endif

/* File: test/fsp_array_model.sv */
// fsp_array_model.sv: behavioural flash array answering debug blank checks
// assumes: check_req is a one-cycle pulse on core_clk; erased is set by the bench
module fsp_array_model
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic check_req,
  input  wire logic erased,
  output logic      done,
  output logic      pass
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;

  assign cnt_next = check_req ? 4'h6 : (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
  always_ff @(posedge core_clk)
  begin
    cnt_reg <= rst_n ? cnt_next : 4'h0;
  end
  // the result is only valid with done; outside it the line shows the inverse
  assign done = (cnt_reg == 4'h1);
  assign pass = done ? erased : ~erased;
endmodule

/* File: test/tb_fsp_flash_security.sv */
// tb_fsp_flash_security.sv: self-checking bench for the flash security block
// assumes: inputs change on falling edges; register reads are scored by a queue
`include "fsp_regs.svh"
module tb_fsp_flash_security;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] KB  = 16'hffb0;
  localparam int          CYC = 10;
  logic        core_clk, rst_n, background_mode_select_pin, dbg_enable_req, bgnd_entry_req;
  logic        reg_wr, reg_rd, reg_from_debug, reg_from_ram, flash_wr, cmd_burst, rd_seen;
  logic        blank_req, erased, blank_check_done, blank_check_pass;
  logic        flash_latch_wr, cmd_start, cmd_reject, secure, debug_enable, bgnd_entry;
  logic [7:0]  nv_options_byte, nv_protect_byte, reg_wdata, reg_rdata, flash_wdata;
  logic [2:0]  reg_addr;
  logic [15:0] flash_addr;
  logic [63:0] nv_backdoor_key;
  logic [7:0]  exp_q[$];
  int          seed = 32'hac090fa0;
  int          bad_count = 0;
  int          compares = 0;

  fsp_flash_security #(.CMD_CYC(CYC)) i_fsp_flash_security
  (
    .core_clk, .rst_n, .nv_options_byte, .nv_protect_byte, .nv_backdoor_key,
    .background_mode_select_pin, .dbg_enable_req, .bgnd_entry_req, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_from_debug, .reg_from_ram, .reg_rdata, .flash_wr,
    .flash_addr, .flash_wdata, .key_base_addr(KB), .blank_check_done, .blank_check_pass,
    .cmd_burst, .flash_latch_wr, .cmd_start, .cmd_reject, .secure, .debug_enable, .bgnd_entry
  );
  fsp_array_model i_fsp_array_model
  (
    .core_clk, .rst_n, .check_req(blank_req), .erased, .done(blank_check_done), .pass(blank_check_pass)
  );

  always #2 core_clk = ~core_clk;

  task automatic stop_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0 && exp_q.size() == 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ************************************************************
  // bus tasks
  // ************************************************************
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic dbg, input logic ram);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    reg_from_debug = dbg;
    reg_from_ram = ram;
    #1;
    if (a == `FSP_OFF_STAT) check(cmd_start, d[7]);
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  // the expected byte is queued here; the monitor below scores it
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    exp_q.push_back(e);
    @(negedge core_clk);
    reg_rd = 1'b0;
  endtask

  always @(posedge core_clk) rd_seen <= reg_rd;
  always @(negedge core_clk)
  begin
    if (rd_seen) check(reg_rdata, exp_q.pop_front());
  end

  task automatic fw(input logic [15:0] a, input logic el, input logic er);
    @(negedge core_clk);
    flash_wr = 1'b1;
    flash_addr = a;
    flash_wdata = 8'($random(seed));
    #1;
    check(flash_latch_wr, el);
    check(cmd_reject, er);
    @(negedge core_clk);
    flash_wr = 1'b0;
  endtask

  // adj repeats each key byte on the next cycle with wrong data, which must be dropped
  task automatic keyseq(input logic [63:0] k, input logic ram, input logic adj);
    wr(`FSP_OFF_CFG, 8'h20, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge core_clk);
      reg_from_ram = ram;
      flash_wr = 1'b1;
      flash_addr = KB + 16'(i);
      flash_wdata = k[8*i +: 8];
      #1;
      if (ram) check(flash_latch_wr, 1'b0);
      if (adj)
      begin
        @(negedge core_clk);
        flash_wdata = ~flash_wdata;
      end
      @(negedge core_clk);
      flash_wr = 1'b0;
    end
    wr(`FSP_OFF_CFG, 8'h00, 1'b0, 1'b1);
    repeat (2) @(negedge core_clk);
  endtask

  task automatic blank(input logic e, input logic exp_sec);
    int n;
    erased = e;
    reg_from_debug = 1'b1;
    @(negedge core_clk);
    blank_req = 1'b1;
    @(negedge core_clk);
    blank_req = 1'b0;
    for (n = 0; n < 50 && !blank_check_done; n++) @(negedge core_clk);
    if (n == 50)
    begin
      bad_count++;
      stop_test();
    end
    else
    begin
      repeat (2) @(negedge core_clk);
      check(secure, exp_sec);
    end
  endtask

  task automatic do_reset(input logic [7:0] opt, input logic pin);
    @(negedge core_clk);
    rst_n = 1'b0;
    nv_options_byte = opt;
    background_mode_select_pin = pin;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    {core_clk, rst_n, reg_wr, reg_rd, flash_wr, cmd_burst, blank_req, erased} = '0;
    {reg_from_debug, reg_from_ram, reg_addr, reg_wdata, flash_addr, flash_wdata} = '0;
    {dbg_enable_req, bgnd_entry_req, background_mode_select_pin} = 3'h7;
    nv_options_byte = 8'h80;
    nv_protect_byte = 8'h80;
    nv_backdoor_key = {$random(seed), $random(seed)};
    do_reset(8'h80, 1'b1);
    check(secure, 1'b1);
    check(debug_enable, 1'b0);
    check(bgnd_entry, 1'b0);
    rd(`FSP_OFF_PROT, 8'h80);
    rd(`FSP_OFF_STAT, 8'hc0);
    wr(`FSP_OFF_PROT, 8'($random(seed)), 1'b0, 1'b1);
    rd(`FSP_OFF_PROT, 8'h80);
    fw(16'h9000, 1'b0, 1'b1);
    fw(16'h81ff, 1'b1, 1'b0);
    wr(`FSP_OFF_PROT, 8'h81, 1'b1, 1'b0);
    rd(`FSP_OFF_PROT, 8'h81);
    fw(16'h9000, 1'b1, 1'b0);
    wr(`FSP_OFF_STAT, 8'h4b, 1'b0, 1'b0);
    rd(`FSP_OFF_STAT, 8'hc0);
    for (int b = 0; b < 2; b++)
    begin
      cmd_burst = b[0];
      wr(`FSP_OFF_STAT, 8'h8b, 1'b0, 1'b0);
      rd(`FSP_OFF_STAT, b ? 8'h80 : 8'h00);
      if (b)
      begin
        wr(`FSP_OFF_STAT, 8'h80, 1'b0, 1'b0);
        rd(`FSP_OFF_STAT, 8'h00);
      end
      repeat (2 * CYC + 8) @(negedge core_clk);
      rd(`FSP_OFF_STAT, 8'hc0);
    end
    keyseq(nv_backdoor_key ^ 64'h1, 1'b1, 1'b0);
    check(secure, 1'b1);
    keyseq(nv_backdoor_key, 1'b0, 1'b0);
    check(secure, 1'b1);
    keyseq(nv_backdoor_key, 1'b1, 1'b1);
    check(secure, 1'b0);
    check(debug_enable, 1'b1);
    check(bgnd_entry, 1'b1);
    do_reset(8'h00, 1'b0);
    check(secure, 1'b1);
    check(bgnd_entry, 1'b1);
    wr(`FSP_OFF_CFG, 8'h20, 1'b0, 1'b1);
    rd(`FSP_OFF_CFG, 8'h00);
    keyseq(nv_backdoor_key, 1'b1, 1'b0);
    check(secure, 1'b1);
    blank(1'b0, 1'b1);
    blank(1'b1, 1'b0);
    do_reset(8'h02, 1'b1);
    check(secure, 1'b0);
    repeat (2) @(negedge core_clk);
    stop_test();
  end
endmodule
